// ### src/eei_pkg.sv
// Package of constants and types for the Ethernet error injector
package eei_pkg;

	// Clock rate and derived periods
	localparam int CLK_HZ = 100000000;
	localparam int SEC_MS = 1000;
	localparam int SEC_CYCLES = CLK_HZ / 1000 * SEC_MS;
	localparam int TEN_SEC_PERIODS = 10;

	// Stream and setting widths
	localparam int DATA_W = 64;
	localparam int BURST_W = 16;

	// Reset values
	localparam logic [BURST_W-1:0] BURST_RST = 16'h0001;

	// Inter-frame gap in idle words, normal and shortened
	localparam logic [3:0] GAP_NORMAL = 4'h2;
	localparam logic [3:0] GAP_SHORT = 4'h1;

	// Rate exponents
	localparam logic [2:0] RATE_EXP_MIN = 3'h2;
	localparam logic [2:0] RATE_EXP_MAX = 3'h7;

	// Field positions inside the outgoing word
	localparam int PRE_LSB = 8;
	localparam int IPCS_LSB = 16;
	localparam int FRAG_BIT = 45;
	localparam int L4CS_LSB = 32;
	localparam int SEQ_LSB = 0;
	localparam int SYNC_LSB = 0;

	// Injection modes
	typedef enum logic [2:0] {
		EEI_OFF,
		EEI_MANUAL,
		EEI_PER_SEC,
		EEI_PER_TEN_SEC,
		EEI_RATE
	} eei_mode_t;

	// Destinations
	typedef enum logic [3:0] {
		EEI_DST_GAP,
		EEI_DST_FCS,
		EEI_DST_PREAMBLE,
		EEI_DST_IPCS,
		EEI_DST_FRAG,
		EEI_DST_L4CS,
		EEI_DST_PATTERN,
		EEI_DST_SEQ,
		EEI_DST_SYMBOL,
		EEI_DST_FEC
	} eei_dest_t;

	// Link speeds
	typedef enum logic [1:0] {
		EEI_SPD_1G,
		EEI_SPD_10G,
		EEI_SPD_25G,
		EEI_SPD_100G
	} eei_speed_t;

	// Word kinds tagged by the frame builder upstream
	typedef enum logic [2:0] {
		EEI_K_IDLE,
		EEI_K_PREAMBLE,
		EEI_K_HEADER,
		EEI_K_PAYLOAD,
		EEI_K_FCS
	} eei_kind_t;

	// Ten to the power n, for n from 0 to 7
	function automatic logic [23:0] eei_pow10(input logic [2:0] n);
		logic [23:0] p;
		p = 24'h000001;
		for (int i = 0; i < 7; i++) begin
			if (i < int'(n)) begin
				p = 24'(p * 24'h00000a);
			end
		end
		return p;
	endfunction : eei_pow10

endpackage : eei_pkg

// ### src/eei_skid_buffer.sv
// Two-entry valid/ready buffer in the data path
`timescale 1ns/100ps
`default_nettype none
module eei_skid_buffer #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outValid = count != '0;

	// Occupancy after this edge, so that ready can be registered
	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end
	assign outData = mem[rdPtr];

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			inReady <= 1'b0;
		end else begin
			count <= next_count;
			inReady <= next_count != (AW+1)'(DEPTH);
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : AW'(wrPtr + 1'b1);
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : AW'(rdPtr + 1'b1);
			end
		end
	end

	overflow_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
		count <= (AW+1)'(DEPTH))
		else $error("Buffer occupancy beyond depth");
endmodule : eei_skid_buffer
`default_nettype wire

// ### src/eei_error_injector.sv
// Error and alarm injection stage on the transmit word stream
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE1 - Enabled alarm is inserted without any break
// RULE2 - Mode off inserts no errors
// RULE3 - Manual trigger inserts exactly burst length, stops
// RULE4 - One burst every one second
// RULE5 - One burst every ten seconds
// RULE6 - One burst per ten-to-N blocks, N 2..7
// RULE7 - In rate mode trigger only reports status
// RULE8 - Burst length sets errors per injection event
// RULE9 - Gap target shortens inter-frame gap
// RULE10 - Checksum target corrupts frame check sequence
// RULE11 - Preamble target alters preamble up to 10G
// RULE12 - IP target corrupts IPv4 header checksum
// RULE13 - Fragment target sends IPv4 data fragmented
// RULE14 - Transport target corrupts TCP/UDP checksum
// RULE15 - Pattern target flips payload pattern bits
// RULE16 - Sequence target corrupts test sequence number
// RULE17 - Symbol target on 10G sends invalid block
// RULE18 - Symbol target at 1G asserts transmit error
// RULE19 - FEC enabled 25G/100G allows symbol errors
// RULE20 - Periods and block counts from own counters
module eei_error_injector #(
	parameter int DATA_W = eei_pkg::DATA_W,
	parameter int BURST_W = eei_pkg::BURST_W,
	parameter int SEC_CYCLES = eei_pkg::SEC_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Operator settings
	input wire eei_pkg::eei_mode_t injectMode,
	input wire eei_pkg::eei_dest_t injectDest,
	input wire eei_pkg::eei_speed_t linkSpeed,
	input wire logic [BURST_W-1:0] burstLength,
	input wire logic [2:0] rateExponent,
	input wire logic manualInject,
	input wire logic alarmEnable,
	input wire logic fecEnable,
	// Incoming word stream
	input wire logic inValid,
	output logic inReady,
	input wire logic [DATA_W-1:0] inData,
	input wire eei_pkg::eei_kind_t inKind,
	input wire logic inLast,
	// Outgoing word stream
	output logic outValid,
	input wire logic outReady,
	output logic [DATA_W-1:0] outData,
	output logic outLast,
	output logic txError,
	output logic fecSymbolError,
	output logic alarmActive,
	// Status
	output logic injectBusy,
	output logic injectStatus,
	output logic [BURST_W-1:0] injectedCount
);
	localparam int BW = DATA_W + 5;

	logic [31:0] cycleCount;
	logic [3:0] secCount;
	logic secTick;
	logic tenSecTick;
	logic [23:0] blockCount;
	logic rateTick;
	logic [2:0] rateN;
	logic manualPrev;
	logic manualEdge;
	logic startBurst;
	logic [BURST_W-1:0] remaining;
	logic [3:0] gapCount;
	logic inFrame;
	logic gapDrop;
	logic hit;
	logic [DATA_W-1:0] next_data;
	logic next_txErr;
	logic next_fecErr;
	logic take;
	logic bufInValid;
	logic bufInReady;
	logic bufOutValid;
	logic [BW-1:0] bufOut;
	logic [DATA_W-1:0] bufData;
	logic bufLast;
	logic bufTxErr;
	logic bufFecErr;

	// One- and ten-second ticks from the free-running counter
	always_ff @(posedge clk) begin // RULE20
		if (!rst_n) begin
			cycleCount <= '0;
			secCount <= '0;
			secTick <= 1'b0;
			tenSecTick <= 1'b0;
		end else begin
			secTick <= 1'b0;
			tenSecTick <= 1'b0;
			if (cycleCount == 32'(SEC_CYCLES - 1)) begin
				cycleCount <= '0;
				secTick <= 1'b1; // RULE4
				if (secCount == 4'(eei_pkg::TEN_SEC_PERIODS - 1)) begin
					secCount <= '0;
					tenSecTick <= 1'b1; // RULE5
				end else begin
					secCount <= 4'(secCount + 1'b1);
				end
			end else begin
				cycleCount <= 32'(cycleCount + 1'b1);
			end
		end
	end

	// Exponent held inside the supported range
	assign rateN = (rateExponent < eei_pkg::RATE_EXP_MIN) ? eei_pkg::RATE_EXP_MIN
		: (rateExponent > eei_pkg::RATE_EXP_MAX) ? eei_pkg::RATE_EXP_MAX
		: rateExponent; // RULE6

	// Block counter for rate mode
	always_ff @(posedge clk) begin // RULE20
		if (!rst_n) begin
			blockCount <= '0;
			rateTick <= 1'b0;
		end else begin
			rateTick <= 1'b0;
			if (injectMode != eei_pkg::EEI_RATE) begin
				blockCount <= '0;
			end else if (take) begin
				if (blockCount >= 24'(eei_pkg::eei_pow10(rateN) - 1'b1)) begin
					blockCount <= '0;
					rateTick <= 1'b1; // RULE6
				end else begin
					blockCount <= 24'(blockCount + 1'b1);
				end
			end
		end
	end

	// Manual trigger edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			manualPrev <= 1'b0;
		end else begin
			manualPrev <= manualInject;
		end
	end
	assign manualEdge = manualInject && !manualPrev;

	always_comb begin
		startBurst = 1'b0;
		case (injectMode)
			eei_pkg::EEI_MANUAL: startBurst = manualEdge; // RULE3
			eei_pkg::EEI_PER_SEC: startBurst = secTick; // RULE4
			eei_pkg::EEI_PER_TEN_SEC: startBurst = tenSecTick; // RULE5
			eei_pkg::EEI_RATE: startBurst = rateTick; // RULE6 RULE7
			default: startBurst = 1'b0; // RULE2
		endcase
	end

	// Remaining errors in the current burst
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			remaining <= '0;
			injectedCount <= '0;
		end else if (injectMode == eei_pkg::EEI_OFF) begin
			remaining <= '0; // RULE2
		end else if (startBurst && remaining == '0) begin
			remaining <= burstLength; // RULE8
			injectedCount <= '0;
		end else if (hit && take) begin
			remaining <= BURST_W'(remaining - 1'b1); // RULE3
			injectedCount <= BURST_W'(injectedCount + 1'b1);
		end
	end

	// Status outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			injectBusy <= 1'b0;
			injectStatus <= 1'b0;
			alarmActive <= 1'b0;
		end else begin
			injectBusy <= remaining != '0;
			injectStatus <= (remaining != '0) || (injectMode == eei_pkg::EEI_RATE); // RULE7
			alarmActive <= alarmEnable; // RULE1
		end
	end

	// Frame tracking for gap shortening
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			inFrame <= 1'b0;
			gapCount <= '0;
		end else if (take) begin
			if (inKind == eei_pkg::EEI_K_IDLE) begin
				inFrame <= 1'b0;
				gapCount <= (gapCount == 4'hf) ? gapCount : 4'(gapCount + 1'b1);
			end else begin
				inFrame <= 1'b1;
				gapCount <= '0;
			end
		end
	end

	// Which word an error lands on
	always_comb begin
		hit = 1'b0;
		gapDrop = 1'b0;
		if (remaining != '0) begin
			case (injectDest)
				eei_pkg::EEI_DST_GAP: begin
					hit = inKind == eei_pkg::EEI_K_IDLE && !inFrame
						&& gapCount >= eei_pkg::GAP_SHORT
						&& gapCount < eei_pkg::GAP_NORMAL; // RULE9
					gapDrop = hit;
				end
				eei_pkg::EEI_DST_FCS: hit = inKind == eei_pkg::EEI_K_FCS;
				eei_pkg::EEI_DST_PREAMBLE: hit = inKind == eei_pkg::EEI_K_PREAMBLE
					&& (linkSpeed == eei_pkg::EEI_SPD_1G
					|| linkSpeed == eei_pkg::EEI_SPD_10G); // RULE11
				eei_pkg::EEI_DST_IPCS: hit = inKind == eei_pkg::EEI_K_HEADER;
				eei_pkg::EEI_DST_FRAG: hit = inKind == eei_pkg::EEI_K_HEADER;
				eei_pkg::EEI_DST_L4CS: hit = inKind == eei_pkg::EEI_K_HEADER;
				eei_pkg::EEI_DST_PATTERN: hit = inKind == eei_pkg::EEI_K_PAYLOAD;
				eei_pkg::EEI_DST_SEQ: hit = inKind == eei_pkg::EEI_K_PAYLOAD;
				eei_pkg::EEI_DST_SYMBOL: hit = inKind != eei_pkg::EEI_K_IDLE
					&& (linkSpeed == eei_pkg::EEI_SPD_1G
					|| linkSpeed == eei_pkg::EEI_SPD_10G);
				eei_pkg::EEI_DST_FEC: hit = fecEnable
					&& (linkSpeed == eei_pkg::EEI_SPD_25G
					|| linkSpeed == eei_pkg::EEI_SPD_100G); // RULE19
				default: hit = 1'b0;
			endcase
		end
	end

	// Corrupt the chosen field
	always_comb begin
		next_data = inData;
		next_txErr = 1'b0;
		next_fecErr = 1'b0;
		if (alarmEnable) begin
			next_txErr = 1'b1; // RULE1
		end
		if (hit && injectMode != eei_pkg::EEI_OFF) begin // RULE2
			case (injectDest)
				eei_pkg::EEI_DST_FCS: next_data = ~inData; // RULE10
				eei_pkg::EEI_DST_PREAMBLE:
					next_data[eei_pkg::PRE_LSB] = ~inData[eei_pkg::PRE_LSB]; // RULE11
				eei_pkg::EEI_DST_IPCS:
					next_data[eei_pkg::IPCS_LSB] = ~inData[eei_pkg::IPCS_LSB]; // RULE12
				eei_pkg::EEI_DST_FRAG:
					next_data[eei_pkg::FRAG_BIT] = 1'b1; // RULE13
				eei_pkg::EEI_DST_L4CS:
					next_data[eei_pkg::L4CS_LSB] = ~inData[eei_pkg::L4CS_LSB]; // RULE14
				eei_pkg::EEI_DST_PATTERN:
					next_data[DATA_W-1] = ~inData[DATA_W-1]; // RULE15
				eei_pkg::EEI_DST_SEQ:
					next_data[eei_pkg::SEQ_LSB] = ~inData[eei_pkg::SEQ_LSB]; // RULE16
				eei_pkg::EEI_DST_SYMBOL: begin
					if (linkSpeed == eei_pkg::EEI_SPD_10G) begin
						next_data[eei_pkg::SYNC_LSB+1:eei_pkg::SYNC_LSB] = 2'h3; // RULE17
					end else begin
						next_txErr = 1'b1; // RULE18
					end
				end
				eei_pkg::EEI_DST_FEC: next_fecErr = 1'b1; // RULE19
				default: next_data = inData;
			endcase
		end
	end

	// Gap words are dropped, which shortens the gap
	assign take = inValid && bufInReady;
	assign inReady = bufInReady;
	assign bufInValid = inValid && !gapDrop; // RULE9

	eei_skid_buffer #(
		.WIDTH(BW),
		.DEPTH(2)
	) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData({2'h0, next_fecErr, next_txErr, inLast, next_data}),
		.outValid(bufOutValid),
		.outReady(outReady || !outValid),
		.outData(bufOut)
	);
	assign bufData = bufOut[DATA_W-1:0];
	assign bufLast = bufOut[DATA_W];
	assign bufTxErr = bufOut[DATA_W+1];
	assign bufFecErr = bufOut[DATA_W+2];

	// Output register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			outValid <= 1'b0;
			outData <= '0;
			outLast <= 1'b0;
			txError <= 1'b0;
			fecSymbolError <= 1'b0;
		end else if (outReady || !outValid) begin
			outValid <= bufOutValid;
			outData <= bufData;
			outLast <= bufLast;
			txError <= bufOutValid && bufTxErr;
			fecSymbolError <= bufOutValid && bufFecErr;
		end
	end

	sequence burst_start_s;
		startBurst && remaining == '0 && injectMode != eei_pkg::EEI_OFF;
	endsequence

	off_no_inject_a: assert property (@(posedge clk) disable iff (!rst_n)
		injectMode == eei_pkg::EEI_OFF |=> remaining == '0) // RULE2
		else $error("Injection active while off");
	burst_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start_s |=> remaining == $past(burstLength)) // RULE8
		else $error("Burst length not loaded");
	manual_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		remaining != '0 && hit && take && injectMode != eei_pkg::EEI_OFF
		|=> remaining == $past(remaining) - 1'b1) // RULE3
		else $error("Burst count not decremented");
	rate_no_manual_a: assert property (@(posedge clk) disable iff (!rst_n)
		injectMode == eei_pkg::EEI_RATE && !rateTick |-> !startBurst) // RULE7
		else $error("Trigger started burst in rate mode");
	sec_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
		secTick |=> !secTick) // RULE4
		else $error("Second tick longer than one cycle");
	ten_sec_a: assert property (@(posedge clk) disable iff (!rst_n)
		tenSecTick |-> secTick) // RULE5
		else $error("Ten second tick off a second boundary");
	alarm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		alarmEnable |=> alarmActive) // RULE1
		else $error("Alarm not held");
	fec_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		next_fecErr |-> fecEnable) // RULE19
		else $error("FEC error without FEC");
	pre_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
		hit && injectDest == eei_pkg::EEI_DST_PREAMBLE
		|-> linkSpeed inside {eei_pkg::EEI_SPD_1G, eei_pkg::EEI_SPD_10G}) // RULE11
		else $error("Preamble hit above 10G");
endmodule : eei_error_injector
`default_nettype wire

// ### bench/eei_link_sink.sv
// Link partner model that takes the outgoing word stream
`timescale 1ns/100ps
`default_nettype none
module eei_link_sink (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Stream acceptance
	output var logic outReady,
	// Behaviour: 0 always ready, 1 random stalls, 2 hold off
	input wire logic [1:0] stallMode
);
	logic [15:0] state = 16'h5a3c;
	initial outReady = 1'b0;
	// Ready changes only away from the sampling edge
	always @(negedge clk) begin
		state <= {state[14:0], state[15] ^ state[13] ^ state[12] ^ state[10]};
		if (!rst_n || stallMode == 2'h2) begin
			outReady <= 1'b0;
		end else if (stallMode == 2'h1) begin
			outReady <= state[0] | state[3];
		end else begin
			outReady <= 1'b1;
		end
	end
endmodule : eei_link_sink
`default_nettype wire

// ### bench/eei_error_injector_tb.sv
// Self-checking bench for the error injector
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checkCount++; if ((ex) !== (got)) begin \
	mismatches++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module eei_error_injector_tb;
	logic clk = 0, rst_n = 0, manual = 0, alarm = 0, fec = 0;
	logic inValid = 0, inLast = 0, loose = 0, t, ee, el, ef, refused;
	logic expTx, expFec, expDrop;
	eei_pkg::eei_mode_t mode = eei_pkg::EEI_OFF;
	eei_pkg::eei_dest_t dest = eei_pkg::EEI_DST_PATTERN;
	eei_pkg::eei_speed_t speed = eei_pkg::EEI_SPD_10G;
	eei_pkg::eei_kind_t inKind = eei_pkg::EEI_K_PAYLOAD;
	logic [15:0] burst = 16'h0001, count, rnd = 16'hc1f5;
	logic [2:0] rateExp = 3'h2;
	logic [63:0] inData = 64'h0, outData, ed, w;
	logic inReady, outValid, outReady, outLast, txError, fecSym, alarmAct;
	logic busy, status;
	logic [1:0] stall = 2'h1;
	logic [63:0] qd[$];
	logic qe[$], ql[$], qf[$];
	int mismatches = 0, checkCount = 0, left = 0, hits = 0, n, gapRun = 0;
	eei_pkg::eei_dest_t dsts[12] = '{eei_pkg::EEI_DST_GAP,
		eei_pkg::EEI_DST_FCS, eei_pkg::EEI_DST_PREAMBLE,
		eei_pkg::EEI_DST_IPCS, eei_pkg::EEI_DST_FRAG,
		eei_pkg::EEI_DST_L4CS, eei_pkg::EEI_DST_PATTERN,
		eei_pkg::EEI_DST_SEQ, eei_pkg::EEI_DST_SYMBOL,
		eei_pkg::EEI_DST_SYMBOL, eei_pkg::EEI_DST_FEC,
		eei_pkg::EEI_DST_FEC};
	eei_pkg::eei_speed_t spds[12] = '{eei_pkg::EEI_SPD_10G,
		eei_pkg::EEI_SPD_10G, eei_pkg::EEI_SPD_1G, eei_pkg::EEI_SPD_10G,
		eei_pkg::EEI_SPD_10G, eei_pkg::EEI_SPD_10G, eei_pkg::EEI_SPD_10G,
		eei_pkg::EEI_SPD_10G, eei_pkg::EEI_SPD_10G, eei_pkg::EEI_SPD_1G,
		eei_pkg::EEI_SPD_25G, eei_pkg::EEI_SPD_100G};
	eei_pkg::eei_kind_t cyc[6] = '{eei_pkg::EEI_K_PREAMBLE,
		eei_pkg::EEI_K_HEADER, eei_pkg::EEI_K_PAYLOAD, eei_pkg::EEI_K_FCS,
		eei_pkg::EEI_K_IDLE, eei_pkg::EEI_K_IDLE};
	eei_pkg::eei_mode_t lmode[3] = '{eei_pkg::EEI_PER_SEC,
		eei_pkg::EEI_PER_TEN_SEC, eei_pkg::EEI_RATE};
	int lo[3] = '{23, 1, 24};
	int hi[3] = '{26, 3, 26};

	always #5 clk = ~clk;

	eei_error_injector #(.SEC_CYCLES(100)) i_eei_error_injector (
		.clk(clk), .rst_n(rst_n), .injectMode(mode), .injectDest(dest),
		.linkSpeed(speed), .burstLength(burst), .rateExponent(rateExp),
		.manualInject(manual), .alarmEnable(alarm), .fecEnable(fec),
		.inValid(inValid), .inReady(inReady), .inData(inData),
		.inKind(inKind), .inLast(inLast), .outValid(outValid),
		.outReady(outReady), .outData(outData), .outLast(outLast),
		.txError(txError), .fecSymbolError(fecSym), .alarmActive(alarmAct),
		.injectBusy(busy), .injectStatus(status), .injectedCount(count));

	eei_link_sink i_eei_link_sink (
		.clk(clk), .rst_n(rst_n), .outReady(outReady), .stallMode(stall));

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	// Reference corruption of one accepted word
	function automatic logic [63:0] expWord(input logic [63:0] d,
		input eei_pkg::eei_kind_t k);
		logic hit;
		logic low;
		hit = 0;
		low = speed inside {eei_pkg::EEI_SPD_1G, eei_pkg::EEI_SPD_10G};
		expTx = alarm;
		expFec = 0;
		expDrop = 0;
		if (mode == eei_pkg::EEI_MANUAL && left > 0) begin
			case (dest)
				eei_pkg::EEI_DST_GAP: hit = k == eei_pkg::EEI_K_IDLE
					&& gapRun >= int'(eei_pkg::GAP_SHORT)
					&& gapRun < int'(eei_pkg::GAP_NORMAL);
				eei_pkg::EEI_DST_FCS: hit = k == eei_pkg::EEI_K_FCS;
				eei_pkg::EEI_DST_PREAMBLE:
					hit = k == eei_pkg::EEI_K_PREAMBLE && low;
				eei_pkg::EEI_DST_IPCS, eei_pkg::EEI_DST_FRAG,
				eei_pkg::EEI_DST_L4CS: hit = k == eei_pkg::EEI_K_HEADER;
				eei_pkg::EEI_DST_PATTERN,
				eei_pkg::EEI_DST_SEQ: hit = k == eei_pkg::EEI_K_PAYLOAD;
				eei_pkg::EEI_DST_SYMBOL: hit = k != eei_pkg::EEI_K_IDLE && low;
				eei_pkg::EEI_DST_FEC: hit = fec && !low;
				default: hit = 0;
			endcase
			if (hit) begin
				case (dest)
					eei_pkg::EEI_DST_GAP: expDrop = 1;
					eei_pkg::EEI_DST_FCS: d = ~d;
					eei_pkg::EEI_DST_PREAMBLE:
						d[eei_pkg::PRE_LSB] = ~d[eei_pkg::PRE_LSB];
					eei_pkg::EEI_DST_IPCS:
						d[eei_pkg::IPCS_LSB] = ~d[eei_pkg::IPCS_LSB];
					eei_pkg::EEI_DST_FRAG: d[eei_pkg::FRAG_BIT] = 1'b1;
					eei_pkg::EEI_DST_L4CS:
						d[eei_pkg::L4CS_LSB] = ~d[eei_pkg::L4CS_LSB];
					eei_pkg::EEI_DST_PATTERN: d[63] = ~d[63];
					eei_pkg::EEI_DST_SEQ:
						d[eei_pkg::SEQ_LSB] = ~d[eei_pkg::SEQ_LSB];
					eei_pkg::EEI_DST_SYMBOL: begin
						if (speed == eei_pkg::EEI_SPD_1G) begin
							expTx = 1;
						end else begin
							d[eei_pkg::SYNC_LSB+:2] = 2'h3;
						end
					end
					eei_pkg::EEI_DST_FEC: expFec = 1;
					default: expDrop = 0;
				endcase
				left--;
			end
		end
		gapRun = (k == eei_pkg::EEI_K_IDLE) ? gapRun + 1 : 0;
		return d;
	endfunction : expWord

	task automatic push(input logic [63:0] d, input eei_pkg::eei_kind_t k,
		input logic l, output logic taken);
		int c;
		logic [63:0] x;
		c = 0;
		taken = 0;
		@(negedge clk);
		inValid = 1;
		inData = d;
		inKind = k;
		inLast = l;
		while (!taken && c < 40) begin
			@(posedge clk);
			taken = inReady;
			c++;
		end
		if (taken) begin
			x = expWord(d, k);
			if (!expDrop) begin
				qd.push_back(x);
				qe.push_back(expTx);
				qf.push_back(expFec);
				ql.push_back(l);
			end
		end
	endtask : push

	task automatic sendMix(input int num);
		logic ok;
		for (int i = 0; i < num; i++) begin
			rnd = lfsr(rnd);
			push({4{rnd}}, cyc[i % 6], i == num - 1, ok);
			`CHK("accepted", 1'b1, ok)
		end
	endtask : sendMix

	task automatic sendN(input int num, input eei_pkg::eei_kind_t k);
		logic ok;
		for (int i = 0; i < num; i++) begin
			rnd = lfsr(rnd);
			push({4{rnd}}, k, i == num - 1, ok);
			`CHK("accepted", 1'b1, ok)
		end
	endtask : sendN

	task automatic drain();
		int c;
		c = 0;
		@(negedge clk);
		inValid = 0;
		while (qd.size() != 0 && c < 400) begin
			@(posedge clk);
			c++;
		end
		`CHK("drained", 0, qd.size())
		repeat (3) @(negedge clk);
	endtask : drain

	task automatic pulse();
		@(negedge clk);
		manual = 1;
		if (mode == eei_pkg::EEI_MANUAL && left == 0) left = int'(burst);
		@(negedge clk);
		manual = 0;
	endtask : pulse

	// Every delivered word against the reference queue
	always @(posedge clk) begin
		if (rst_n && outValid && outReady) begin
			ed = qd.pop_front();
			ee = qe.pop_front();
			ef = qf.pop_front();
			el = ql.pop_front();
			if (loose) begin
				hits += int'(ed !== outData);
			end else begin
				`CHK("outData", ed, outData)
				`CHK("txError", ee, txError)
				`CHK("fecSymbolError", ef, fecSym)
				`CHK("alarmActive", alarm, alarmAct)
				`CHK("outLast", el, outLast)
			end
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checkCount, mismatches);
		if (mismatches == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	initial begin
		#400000;
		mismatches++;
		results();
	end

	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst_n = 1;
		// Off with a trigger and the alarm on
		alarm = 1;
		pulse();
		sendN(6, eei_pkg::EEI_K_PAYLOAD);
		drain();
		`CHK("busy", 1'b0, busy)
		alarm = 0;
		// Manual bursts for each destination over a mixed frame stream
		mode = eei_pkg::EEI_MANUAL;
		fec = 1;
		for (int i = 0; i < 12; i++) begin
			dest = dsts[i];
			speed = spds[i];
			burst = 16'(i % 3 + 1);
			pulse();
			@(negedge clk);
			`CHK("busy", 1'b1, busy)
			sendMix(24);
			drain();
			`CHK("busy", 1'b0, busy)
			`CHK("count", 16'(i % 3 + 1), count)
		end
		speed = eei_pkg::EEI_SPD_10G;
		// Trigger in rate mode only reports
		mode = eei_pkg::EEI_RATE;
		rateExp = 3'h7;
		pulse();
		sendN(10, eei_pkg::EEI_K_PAYLOAD);
		drain();
		`CHK("status", 1'b1, status)
		// Receiver holds off until the buffer refuses
		mode = eei_pkg::EEI_OFF;
		stall = 2'h2;
		refused = 0;
		n = 0;
		while (!refused && n < 8) begin
			rnd = lfsr(rnd);
			w = {4{rnd}};
			push(w, eei_pkg::EEI_K_PAYLOAD, 1'b0, t);
			refused = ~t;
			n++;
		end
		`CHK("refused", 1'b1, refused)
		stall = 2'h1;
		push(w, eei_pkg::EEI_K_PAYLOAD, 1'b0, t);
		sendN(20, eei_pkg::EEI_K_PAYLOAD);
		drain();
		// Periodic and rate bursts counted over a long stream
		stall = 2'h0;
		loose = 1;
		dest = eei_pkg::EEI_DST_PATTERN;
		burst = 16'h0001;
		rateExp = 3'h2;
		for (int i = 0; i < 3; i++) begin
			mode = eei_pkg::EEI_OFF;
			repeat (4) @(negedge clk);
			mode = lmode[i];
			hits = 0;
			sendN(2500, eei_pkg::EEI_K_PAYLOAD);
			drain();
			`CHK("burst count", 1'b1, hits >= lo[i] && hits <= hi[i])
		end
		results();
	end
endmodule : eei_error_injector_tb
`default_nettype wire
